// *** tb/posl_strap_board.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// board strap resistors and pin-2 driver
// ------------------------------------------------------------
module posl_strap_board (
    input wire logic [posl_pkg::STRAP_W-1:0] strap_value,
    input wire logic stop_n,
    input wire logic [posl_pkg::STRAP_W-1:0] strap_pin_out,
    input wire logic [posl_pkg::STRAP_W-1:0] strap_pin_oe_n,
    input wire logic ref_clock_out_zero_pin_out,
    input wire logic ref_clock_out_zero_pin_oe_n,
    output logic [posl_pkg::STRAP_W-1:0] strap_pin_in,
    output logic ref_clock_out_zero_pin_in
);
    // resistor level when undriven, device level when driven
    always_comb begin
        for (int i = 0; i < posl_pkg::STRAP_W; i++) begin
            strap_pin_in[i] = strap_pin_oe_n[i] ? strap_value[i] : strap_pin_out[i];
        end
        ref_clock_out_zero_pin_in = ref_clock_out_zero_pin_oe_n ? stop_n : ref_clock_out_zero_pin_out;
    end
endmodule

`default_nettype wire

// *** tb/test_posl_strap_latch.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_posl_strap_latch;
    localparam int unsigned N = 8;
    logic clk, rstn, supply_ok, power_down_n, stop_n, mem_in;
    logic [7:0] cnt = 8'h00;
    logic [7:0] cnt_prev, reg_addr;
    logic [4:0] strap_value, strap_pin_in, strap_pin_out, strap_pin_oe_n;
    logic ref_clock_out_zero_pin_in, ref_clock_out_zero_pin_out, ref_clock_out_zero_pin_oe_n, pt, pcmp, pcmp_oe_n, pcs, ref_mode;
    logic [12:0] fan;
    logic [3:0] fs;
    logic [11:0] pf, qf;
    logic [1:0] spr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, mem_prev, src_prev, ref_prev;
    int err_count, n_compared;
    logic [11:0] proc_tab [16] = '{12'h460, 12'h456, 12'h44C, 12'h442, 12'h438, 12'h42E,
        12'h424, 12'h410, 12'h3FC, 12'h535, 12'h535, 12'h535, 12'h3B6, 12'h3E8, 12'h3E8, 12'h3E8};
    logic [11:0] pci_tab [16] = '{12'h175, 12'h172, 12'h16E, 12'h16B, 12'h168, 12'h164,
        12'h161, 12'h15A, 12'h154, 12'h14D, 12'h14D, 12'h14D, 12'h13D, 12'h14D, 12'h14D, 12'h14D};
    logic [1:0] spr_tab [16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1};

    assign mem_in = cnt[1] ^ cnt[2];

    posl_strap_latch #(.SAMPLE_CYCLES(N)) posl_strap_latch_inst (
        .clk(clk), .rstn(rstn), .supply_ok(supply_ok), .power_down_n(power_down_n),
        .mem_clock_fanout_in(mem_in), .proc_clk_src(cnt[0]), .ref_clk_src(cnt[1]),
        .pci_clk_src(cnt[2]), .usb_clk_src(cnt[3]), .sio_clk_src(cnt[4]),
        .strap_pin_in(strap_pin_in), .strap_pin_out(strap_pin_out),
        .strap_pin_oe_n(strap_pin_oe_n), .ref_clock_out_zero_pin_in(ref_clock_out_zero_pin_in),
        .ref_clock_out_zero_pin_out(ref_clock_out_zero_pin_out), .ref_clock_out_zero_pin_oe_n(ref_clock_out_zero_pin_oe_n),
        .mem_clock_fanout_out(fan), .proc_clock_true(pt), .proc_clock_comp_out(pcmp),
        .proc_clock_comp_oe_n(pcmp_oe_n), .proc_clock_chipset(pcs), .freq_select_strap(fs),
        .proc_freq_tenth_mhz(pf), .pci_freq_tenth_mhz(qf), .spread_mode(spr),
        .ref_mode(ref_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    posl_strap_board posl_strap_board_inst (
        .strap_value(strap_value), .stop_n(stop_n), .strap_pin_out(strap_pin_out),
        .strap_pin_oe_n(strap_pin_oe_n), .ref_clock_out_zero_pin_out(ref_clock_out_zero_pin_out),
        .ref_clock_out_zero_pin_oe_n(ref_clock_out_zero_pin_oe_n), .strap_pin_in(strap_pin_in), .ref_clock_out_zero_pin_in(ref_clock_out_zero_pin_in)
    );

    // ------------------------------------------------------------
    // clock, sources and one-cycle-old copies
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cnt <= cnt + 8'h01;
        cnt_prev <= cnt;
        mem_prev <= mem_in;
        src_prev <= cnt[0];
        ref_prev <= cnt[1];
    end

    // ------------------------------------------------------------
    // compare, bus and sequence tasks
    // ------------------------------------------------------------
    task automatic summarize;
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic power_up(input logic [4:0] s, input bit glitch);
        int k;
        @(posedge clk);
        rstn <= 1'b0;
        supply_ok <= 1'b0;
        strap_value <= s;
        tick(10);
        @(posedge clk);
        rstn <= 1'b1;
        tick(3);
        chk(strap_pin_oe_n, 32'h1F);
        rdc(posl_pkg::REG_STATUS, 32'h10);
        if (glitch) begin
            @(posedge clk);
            supply_ok <= 1'b1;
            repeat (N - 2) @(posedge clk);
            supply_ok <= 1'b0;
            @(posedge clk);
        end
        @(posedge clk);
        supply_ok <= 1'b1;
        k = 0;
        while (strap_pin_oe_n !== 5'h00 && k < 40) begin
            tick(1);
            k++;
            if (strap_pin_oe_n !== 5'h00) chk(strap_pin_oe_n, 32'h1F);
        end
        chk(32'(k), 32'(N + 3));
        if (k >= 40) begin
            err_count++;
            summarize;
        end
    endtask

    task automatic check_run(input logic [4:0] s);
        logic [3:0] f;
        f = s[3:0];
        rdc(posl_pkg::REG_STATUS, 32'h1E);
        rdc(posl_pkg::REG_STRAPS, {27'h0, s});
        rdc(posl_pkg::REG_FREQ, {4'h0, pci_tab[f], 4'h0, proc_tab[f]});
        rdc(posl_pkg::REG_SPREAD, {30'h0, spr_tab[f]});
        chk({ref_mode, fs}, {27'h0, s});
        chk({qf, pf, spr}, {pci_tab[f], proc_tab[f], spr_tab[f]});
        chk(ref_clock_out_zero_pin_oe_n, {~s[4]});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        supply_ok = 1'b0;
        power_down_n = 1'b1;
        stop_n = 1'b1;
        strap_value = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        n_compared = 0;
        for (int i = 0; i < 16; i++) begin
            power_up({i[0], i[3:0]}, i == 0);
            check_run({i[0], i[3:0]});
        end
        @(posedge clk);
        strap_value <= 5'h00;
        supply_ok <= 1'b0;
        tick(N + 4);
        rdc(posl_pkg::REG_STRAPS, 32'h1F);
        chk(fs, 32'hF);
        @(posedge clk);
        supply_ok <= 1'b1;
        repeat (8) begin
            tick(1);
            chk(fan, {19'h0, {13{mem_prev}}});
            chk({pt, pcs, pcmp}, {src_prev, src_prev, ~src_prev});
            chk({ref_clock_out_zero_pin_out, strap_pin_out[0]}, {ref_prev, ref_prev});
            chk({strap_pin_oe_n, strap_pin_out}, {5'h00, cnt_prev[2], cnt_prev[4:1]});
        end
        wr(posl_pkg::REG_CTRL, 32'h0);
        tick(2);
        chk(fan, 32'h0);
        rdc(posl_pkg::REG_CTRL, 32'h0);
        wr(posl_pkg::REG_CTRL, 32'h1);
        wr(posl_pkg::REG_STATUS, 32'hFFFFFFFF);
        wr(posl_pkg::REG_STRAPS, 32'h0);
        rdc(posl_pkg::REG_STRAPS, 32'h1F);
        rdc(8'h20, 32'h0);
        tick(1);
        chk(reg_rdata, 32'h0);
        rdc(posl_pkg::REG_CTRL, 32'h1);
        @(posedge clk);
        power_down_n <= 1'b0;
        tick(3);
        repeat (4) begin
            tick(1);
            chk(fan, 32'h0);
            chk({pt, pcs, ref_clock_out_zero_pin_out, strap_pin_out, strap_pin_oe_n}, 32'h0);
            chk(pcmp_oe_n, 32'h1);
        end
        rdc(posl_pkg::REG_STATUS, 32'h0E);
        @(posedge clk);
        power_down_n <= 1'b1;
        power_up(5'h05, 1'b0);
        check_run(5'h05);
        @(posedge clk);
        stop_n <= 1'b0;
        tick(3);
        chk({pt, pcs, pcmp_oe_n, ref_clock_out_zero_pin_oe_n}, 32'h3);
        chk(fan, {19'h0, {13{mem_prev}}});
        @(posedge clk);
        stop_n <= 1'b1;
        tick(3);
        chk(pcmp_oe_n, 32'h0);
        summarize;
    end
endmodule

`default_nettype wire

// *** verilog/posl_pkg.sv ***
package posl_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int STRAP_W = 5;
    localparam int FANOUT_W = 13;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TIMER_W = 16;
    localparam int FREQ_W = 12;

    // ------------------------------------------------------------
    // strap pin positions
    // ------------------------------------------------------------
    localparam int PIN_FS0 = 0;
    localparam int PIN_FS1 = 1;
    localparam int PIN_FS2 = 2;
    localparam int PIN_FS3 = 3;
    localparam int PIN_MODE = 4;
    localparam int FS_W = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SAMPLE_TIME_NS = 2000000;
    localparam int unsigned SAMPLE_CYCLES =
        (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STRAPS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FREQ = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_SPREAD = 8'h10;

    localparam int CTRL_FANOUT_EN_BIT = 0;
    localparam logic CTRL_FANOUT_EN_RST = 1'b1;
    localparam int STATUS_CAPTURED_BIT = 2;
    localparam int STATUS_SUPPLY_BIT = 3;
    localparam int STATUS_PWR_BIT = 4;
    localparam int FREQ_PCI_LSB = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_WAIT_SUPPLY = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN = 2'b10
    } posl_state_t;

    typedef enum logic [1:0] {
        SPREAD_OFF = 2'b00,
        SPREAD_DOWN_HALF = 2'b01,
        SPREAD_CTR_QUARTER = 2'b10,
        SPREAD_CTR_HALF = 2'b11
    } posl_spread_t;

endpackage

// *** verilog/posl_sample_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module posl_sample_timer #(
    parameter int CNT_W = 16,
    parameter int unsigned COUNT = 40000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic done
);

    logic [CNT_W-1:0] cnt_q;
    logic done_q;

    // ------------------------------------------------------------
    // interval counter, cleared whenever run drops
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || !run) begin
            cnt_q <= '0;
        end else if (!done_q) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || !run) begin
            done_q <= 1'b0;
        end else if (cnt_q == CNT_W'(COUNT - 1)) begin
            done_q <= 1'b1;
        end
    end

    assign done = done_q;

endmodule

`default_nettype wire

// *** verilog/posl_strap_latch.sv ***
// Summary of operation
// - thirteen fan-out outputs copy memory clock input
// - power-down low turns fan-out outputs off
// - five shared pins are inputs at power-up
// - first 2 ms reserved for strap sampling
// - shared pins undriven during sampling interval
// - pin low latches 0, high latches 1
// - at expiry latch pins, then drive clocks
// - interval starts only after supply detected
// - latched straps change only on power cycle
// - after enable, pins carry selected frequency
// - first processor clock period may be short
// - four strap bits choose frequencies and spread
// - mode strap picks ref output or stop input
// - power-down: comp tri-stated, others driven low
`timescale 1ns/10ps
`default_nettype none

module posl_strap_latch #(
    parameter int unsigned SAMPLE_CYCLES = posl_pkg::SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic supply_ok,
    input wire logic power_down_n,
    input wire logic mem_clock_fanout_in,
    input wire logic proc_clk_src,
    input wire logic ref_clk_src,
    input wire logic pci_clk_src,
    input wire logic usb_clk_src,
    input wire logic sio_clk_src,
    input wire logic [posl_pkg::STRAP_W-1:0] strap_pin_in,
    output logic [posl_pkg::STRAP_W-1:0] strap_pin_out,
    output logic [posl_pkg::STRAP_W-1:0] strap_pin_oe_n,
    input wire logic ref_clock_out_zero_pin_in,
    output logic ref_clock_out_zero_pin_out,
    output logic ref_clock_out_zero_pin_oe_n,
    output logic [posl_pkg::FANOUT_W-1:0] mem_clock_fanout_out,
    output logic proc_clock_true,
    output logic proc_clock_comp_out,
    output logic proc_clock_comp_oe_n,
    output logic proc_clock_chipset,
    output logic [posl_pkg::FS_W-1:0] freq_select_strap,
    output logic [posl_pkg::FREQ_W-1:0] proc_freq_tenth_mhz,
    output logic [posl_pkg::FREQ_W-1:0] pci_freq_tenth_mhz,
    output logic [1:0] spread_mode,
    output logic ref_mode,
    input wire logic [posl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [posl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [posl_pkg::DATA_W-1:0] reg_rdata
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    posl_pkg::posl_state_t state_q;
    posl_pkg::posl_state_t state_d;
    logic timer_done;
    logic running;
    logic proc_stop;
    logic proc_en;
    logic [posl_pkg::STRAP_W-1:0] straps_q;
    logic captured_q;
    logic fanout_en_q;
    logic [posl_pkg::FANOUT_W-1:0] fanout_q;
    logic [posl_pkg::STRAP_W-1:0] pin_out_q;
    logic [posl_pkg::STRAP_W-1:0] pin_oe_n_q;
    logic ref_clock_out_zero_out_q;
    logic ref_clock_out_zero_oe_n_q;
    logic true_q;
    logic comp_q;
    logic comp_oe_n_q;
    logic chipset_q;
    logic [posl_pkg::FREQ_W-1:0] proc_freq_q;
    logic [posl_pkg::FREQ_W-1:0] pci_freq_q;
    posl_pkg::posl_spread_t spread_q;
    logic [posl_pkg::DATA_W-1:0] rdata_q;
    logic [posl_pkg::FS_W-1:0] fs;

    // ------------------------------------------------------------
    // frequency table lookup
    // ------------------------------------------------------------
    function automatic logic [2*posl_pkg::FREQ_W-1:0] freq_lookup(
        input logic [posl_pkg::FS_W-1:0] sel
    );
        logic [2*posl_pkg::FREQ_W-1:0] r;
        r = '0;
        case (sel)
            4'hF, 4'hE, 4'hD: r = {12'h3E8, 12'h14D};
            4'hC: r = {12'h3B6, 12'h13D};
            4'hB, 4'hA, 4'h9: r = {12'h535, 12'h14D};
            4'h8: r = {12'h3FC, 12'h154};
            4'h7: r = {12'h410, 12'h15A};
            4'h6: r = {12'h424, 12'h161};
            4'h5: r = {12'h42E, 12'h164};
            4'h4: r = {12'h438, 12'h168};
            4'h3: r = {12'h442, 12'h16B};
            4'h2: r = {12'h44C, 12'h16E};
            4'h1: r = {12'h456, 12'h172};
            4'h0: r = {12'h460, 12'h175};
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic posl_pkg::posl_spread_t spread_lookup(
        input logic [posl_pkg::FS_W-1:0] sel
    );
        posl_pkg::posl_spread_t r;
        r = posl_pkg::SPREAD_OFF;
        case (sel)
            4'hF, 4'hB: r = posl_pkg::SPREAD_DOWN_HALF;
            4'hE, 4'hA: r = posl_pkg::SPREAD_CTR_QUARTER;
            4'hD, 4'h9: r = posl_pkg::SPREAD_CTR_HALF;
            default: r = posl_pkg::SPREAD_OFF;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // sampling interval timer
    // ------------------------------------------------------------
    posl_sample_timer #(
        .CNT_W(posl_pkg::TIMER_W),
        .COUNT(SAMPLE_CYCLES)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .run(state_q == posl_pkg::ST_SAMPLE),
        .done(timer_done)
    );

    // ------------------------------------------------------------
    // power-up sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            posl_pkg::ST_WAIT_SUPPLY: begin
                if (supply_ok) begin
                    state_d = posl_pkg::ST_SAMPLE;
                end
            end
            posl_pkg::ST_SAMPLE: begin
                if (!supply_ok) begin
                    state_d = posl_pkg::ST_WAIT_SUPPLY;
                end else if (timer_done) begin
                    state_d = posl_pkg::ST_RUN;
                end
            end
            posl_pkg::ST_RUN: state_d = posl_pkg::ST_RUN;
            default: state_d = posl_pkg::ST_WAIT_SUPPLY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= posl_pkg::ST_WAIT_SUPPLY;
        end else begin
            state_q <= state_d;
        end
    end

    assign running = (state_q == posl_pkg::ST_RUN);

    // ------------------------------------------------------------
    // strap capture, cleared only by power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            straps_q <= '0;
            captured_q <= 1'b0;
        end else if (state_q == posl_pkg::ST_SAMPLE && supply_ok && timer_done) begin
            straps_q <= strap_pin_in;
            captured_q <= 1'b1;
        end
    end

    assign fs = straps_q[posl_pkg::PIN_FS3:posl_pkg::PIN_FS0];

    // ------------------------------------------------------------
    // frequency and spread selection
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            proc_freq_q <= '0;
            pci_freq_q <= '0;
            spread_q <= posl_pkg::SPREAD_OFF;
        end else begin
            {proc_freq_q, pci_freq_q} <= freq_lookup(fs);
            spread_q <= spread_lookup(fs);
        end
    end

    // ------------------------------------------------------------
    // shared strap pins
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || !running) begin
            pin_oe_n_q <= '1;
            pin_out_q <= '0;
        end else begin
            pin_oe_n_q <= '0;
            pin_out_q[posl_pkg::PIN_FS0] <= power_down_n & ref_clk_src;
            pin_out_q[posl_pkg::PIN_FS1] <= power_down_n & pci_clk_src;
            pin_out_q[posl_pkg::PIN_FS2] <= power_down_n & usb_clk_src;
            pin_out_q[posl_pkg::PIN_FS3] <= power_down_n & sio_clk_src;
            pin_out_q[posl_pkg::PIN_MODE] <= power_down_n & pci_clk_src;
        end
    end

    // ------------------------------------------------------------
    // reference output or processor stop input
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || !running || !straps_q[posl_pkg::PIN_MODE]) begin
            ref_clock_out_zero_oe_n_q <= 1'b1;
            ref_clock_out_zero_out_q <= 1'b0;
        end else begin
            ref_clock_out_zero_oe_n_q <= 1'b0;
            ref_clock_out_zero_out_q <= power_down_n & ref_clk_src;
        end
    end

    assign proc_stop = !straps_q[posl_pkg::PIN_MODE] && !ref_clock_out_zero_pin_in;
    assign proc_en = running && power_down_n && !proc_stop;

    // ------------------------------------------------------------
    // processor clocks; enabling may cut one period short
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            true_q <= 1'b0;
            comp_q <= 1'b0;
            comp_oe_n_q <= 1'b1;
            chipset_q <= 1'b0;
        end else begin
            true_q <= proc_en & proc_clk_src;
            chipset_q <= proc_en & proc_clk_src;
            comp_q <= proc_en & ~proc_clk_src;
            comp_oe_n_q <= ~proc_en;
        end
    end

    // ------------------------------------------------------------
    // memory clock fan-out
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || !power_down_n || !fanout_en_q) begin
            fanout_q <= '0;
        end else begin
            fanout_q <= {posl_pkg::FANOUT_W{mem_clock_fanout_in}};
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fanout_en_q <= posl_pkg::CTRL_FANOUT_EN_RST;
        end else if (reg_wr && reg_addr == posl_pkg::REG_CTRL) begin
            fanout_en_q <= reg_wdata[posl_pkg::CTRL_FANOUT_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || !reg_rd) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            case (reg_addr)
                posl_pkg::REG_CTRL: rdata_q[posl_pkg::CTRL_FANOUT_EN_BIT] <= fanout_en_q;
                posl_pkg::REG_STATUS: begin
                    rdata_q[$bits(state_q)-1:0] <= state_q;
                    rdata_q[posl_pkg::STATUS_CAPTURED_BIT] <= captured_q;
                    rdata_q[posl_pkg::STATUS_SUPPLY_BIT] <= supply_ok;
                    rdata_q[posl_pkg::STATUS_PWR_BIT] <= power_down_n;
                end
                posl_pkg::REG_STRAPS: rdata_q[posl_pkg::STRAP_W-1:0] <= straps_q;
                posl_pkg::REG_FREQ: begin
                    rdata_q[posl_pkg::FREQ_W-1:0] <= proc_freq_q;
                    rdata_q[posl_pkg::FREQ_PCI_LSB+:posl_pkg::FREQ_W] <= pci_freq_q;
                end
                posl_pkg::REG_SPREAD: rdata_q[$bits(spread_q)-1:0] <= spread_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign strap_pin_out = pin_out_q;
    assign strap_pin_oe_n = pin_oe_n_q;
    assign ref_clock_out_zero_pin_out = ref_clock_out_zero_out_q;
    assign ref_clock_out_zero_pin_oe_n = ref_clock_out_zero_oe_n_q;
    assign mem_clock_fanout_out = fanout_q;
    assign proc_clock_true = true_q;
    assign proc_clock_comp_out = comp_q;
    assign proc_clock_comp_oe_n = comp_oe_n_q;
    assign proc_clock_chipset = chipset_q;
    assign freq_select_strap = fs;
    assign proc_freq_tenth_mhz = proc_freq_q;
    assign pci_freq_tenth_mhz = pci_freq_q;
    assign spread_mode = spread_q;
    assign ref_mode = straps_q[posl_pkg::PIN_MODE];
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_capture;
        state_q == posl_pkg::ST_SAMPLE && supply_ok && timer_done;
    endsequence

    sequence s_pins_driven;
        ##1 running ##1 (pin_oe_n_q == '0);
    endsequence

    property p_fanout_copy;
        @(posedge clk) disable iff (!rstn)
        (power_down_n && fanout_en_q) |=>
            (fanout_q == {posl_pkg::FANOUT_W{$past(mem_clock_fanout_in)}});
    endproperty
    a_fanout_copy: assert property (p_fanout_copy) else $error("fanout mismatch");

    property p_fanout_off;
        @(posedge clk) disable iff (!rstn)
        !power_down_n |=> (fanout_q == '0);
    endproperty
    a_fanout_off: assert property (p_fanout_off) else $error("fanout on in power-down");

    property p_pins_hiz;
        @(posedge clk) disable iff (!rstn)
        !running |=> (pin_oe_n_q == '1);
    endproperty
    a_pins_hiz: assert property (p_pins_hiz) else $error("strap pin driven early");

    property p_capture;
        @(posedge clk) disable iff (!rstn)
        s_capture |=> (straps_q == $past(strap_pin_in)) && captured_q;
    endproperty
    a_capture: assert property (p_capture) else $error("strap capture wrong");

    property p_drive_after;
        @(posedge clk) disable iff (!rstn)
        s_capture |-> s_pins_driven;
    endproperty
    a_drive_after: assert property (p_drive_after) else $error("pins not driven");

    property p_supply_gate;
        @(posedge clk) disable iff (!rstn)
        (state_q == posl_pkg::ST_WAIT_SUPPLY && !supply_ok) |=>
            (state_q == posl_pkg::ST_WAIT_SUPPLY);
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("start without supply");

    property p_straps_hold;
        @(posedge clk) disable iff (!rstn)
        captured_q |=> $stable(straps_q) && captured_q;
    endproperty
    a_straps_hold: assert property (p_straps_hold) else $error("straps changed");

    property p_proc_idle;
        @(posedge clk) disable iff (!rstn)
        !running |=> !true_q && !chipset_q && comp_oe_n_q;
    endproperty
    a_proc_idle: assert property (p_proc_idle) else $error("proc clock early");

    property p_spread;
        @(posedge clk) disable iff (!rstn)
        (fs == 4'hC) [*2] |-> (spread_q == posl_pkg::SPREAD_OFF && proc_freq_q == 12'h3B6);
    endproperty
    a_spread: assert property (p_spread) else $error("table lookup wrong");

    property p_mode_pin;
        @(posedge clk) disable iff (!rstn)
        (running && !straps_q[posl_pkg::PIN_MODE]) |=> ref_clock_out_zero_oe_n_q;
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("stop pin driven");

    property p_power_down;
        @(posedge clk) disable iff (!rstn)
        (running && !power_down_n) |=> comp_oe_n_q && !true_q && (pin_out_q == '0);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down outputs wrong");

endmodule

`default_nettype wire
